// >>> bench/kms_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module kms_dev_model (
  // pull-downs from the host
  input wire logic clk_oe,
  input wire logic dat_oe,
  // resolved line levels
  output logic line_clk,
  output logic line_dat
);
  logic clk_low = 1'b0;
  logic dat_low = 1'b0;

  // pulled-up lines: low while any party pulls
  assign line_clk = !(clk_oe || clk_low);
  assign line_dat = !(dat_oe || dat_low);

  // one clock pulse, 320 ns; data set up before the fall
  task automatic pulse();
    #80 clk_low = 1'b1;
    #160 clk_low = 1'b0;
    #80;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [10:0] fr;
    fr = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_low = !fr[i];
      pulse();
    end
    dat_low = 1'b0;
  endtask

  task automatic recv_byte(output logic [9:0] got, output logic ok);
    int n;
    n = 0;
    // wait for data low with clock released
    while (!(line_clk && !line_dat) && n < 5000) begin
      #40;
      n++;
    end
    ok = (n < 5000);
    for (int i = 0; i < 10; i++) begin
      pulse();
      got[i] = line_dat;
    end
    // acknowledge the stop bit anyway
    dat_low = 1'b1;
    pulse();
    dat_low = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> bench/kms_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module kms_chk
  import kms_pkg::*;
#(
  parameter int INHIBIT_CYC = KMS_INHIBIT_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // pointer link and requests
  input wire logic pointer_line_clk_oe,
  input wire logic pointer_line_dat_oe,
  input wire logic irq_group_b_rx,
  input wire logic irq_group_d_tx
);
  logic [15:0] run_reg;
  logic req;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign req = hsel && hready && htrans[1];

  // length of the current clock pull-down run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 16'h0000;
    end else begin
      run_reg <= pointer_line_clk_oe ? run_reg + 16'h0001 : 16'h0000;
    end
  end

  rd_wait_a:
    assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase without one wait state");
  wr_ready_a:
    assert property (req && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  upper_zero_a:
    assert property (req && !hwrite |=> ##1 hrdata[31:8] == 24'h000000)
    else $error("read data wider than one byte");
  rts_order_a:
    assert property ($fell(pointer_line_clk_oe) |-> pointer_line_dat_oe)
    else $error("clock released without data pulled low");
  inhibit_len_a:
    assert property ($fell(pointer_line_clk_oe) |-> run_reg == INHIBIT_CYC)
    else $error("clock inhibit of wrong length");
  inhibit_quiet_a:
    assert property ($rose(pointer_line_clk_oe)
      |-> (pointer_line_clk_oe && !pointer_line_dat_oe)[*8])
    else $error("data pulled during clock inhibit");
  clk_free_a:
    assert property ($fell(pointer_line_clk_oe) |=> !pointer_line_clk_oe[*8])
    else $error("host pulled clock after request");
  tx_busy_irq_a:
    assert property ($rose(pointer_line_clk_oe) |-> !irq_group_d_tx)
    else $error("tx request high while sending");
  // a data read clears two edges on; a disable takes one edge longer
  rx_clear_a:
    assert property ($fell(irq_group_b_rx) |->
      $past(req && !hwrite && haddr == KMS_KBD_DATA_ADDR, 2)
      || $past(req && hwrite && haddr == KMS_KBD_CTL_ADDR, 3))
    else $error("rx request dropped without a cause");
endmodule

bind kms_top kms_chk #(.INHIBIT_CYC(INHIBIT_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata),
  .pointer_line_clk_oe(pointer_line_clk_oe),
  .pointer_line_dat_oe(pointer_line_dat_oe),
  .irq_group_b_rx(irq_group_b_rx), .irq_group_d_tx(irq_group_d_tx)
);

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import kms_pkg::*;
;
  localparam int INH = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = KMS_WORD_RST;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = KMS_WORD_RST;
  logic hreadyout;
  logic [31:0] hrdata;
  logic kc, kd, pc, pd, kco, kdo, pco, pdo;
  logic [3:0] irq;
  logic hresp;
  logic [3:0] lo;
  logic [7:0] rx_busy_flag [2] = '{8'ha5, 8'h07};
  int fail_count = 0;
  int check_count = 0;

  always #20 hclk = ~hclk;

  kms_top #(.INHIBIT_CYC(INH)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .kbd_line_clk_i(kc), .kbd_line_clk_o(lo[3]),
    .kbd_line_clk_oe(kco), .kbd_line_dat_i(kd), .kbd_line_dat_o(lo[2]),
    .kbd_line_dat_oe(kdo), .pointer_line_clk_i(pc),
    .pointer_line_clk_o(lo[1]), .pointer_line_clk_oe(pco),
    .pointer_line_dat_i(pd), .pointer_line_dat_o(lo[0]),
    .pointer_line_dat_oe(pdo), .irq_group_b_tx(irq[3]),
    .irq_group_b_rx(irq[2]), .irq_group_d_tx(irq[1]),
    .irq_group_d_rx(irq[0])
  );
  kms_dev_model i_kbd_dev (
    .clk_oe(kco), .dat_oe(kdo), .line_clk(kc), .line_dat(kd)
  );
  kms_dev_model i_ptr_dev (
    .clk_oe(pco), .dat_oe(pdo), .line_clk(pc), .line_dat(pd)
  );

  // ----------------------------------------------------------------
  // test end, check, delay and bus tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h000000, d}, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, KMS_WORD_RST, r);
    chk(r, exp);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] got;
    logic ok;
    logic [31:0] r;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({28'h0, irq}, 32'h0);
    chk({27'h0, hresp, lo}, 32'h0);
    rdc(KMS_KBD_CTL_ADDR, 32'h03);
    rdc(KMS_PTR_CTL_ADDR, 32'h03);
    rdc(32'h03200000, 32'h0);
    wr(KMS_KBD_DATA_ADDR, 8'h55);
    tick(4);
    chk({31'h0, kco}, 32'h0);
    wr(KMS_KBD_CTL_ADDR, 8'h03);
    tick(3);
    chk({30'h0, kco, kdo}, 32'h3);
    rdc(KMS_KBD_CTL_ADDR, 32'h00);
    wr(KMS_KBD_CTL_ADDR, 8'hf4);
    tick(3);
    rdc(KMS_KBD_CTL_ADDR, 32'h03);
    wr(KMS_KBD_CTL_ADDR, 8'h08);
    wr(KMS_PTR_CTL_ADDR, 8'h08);
    rdc(KMS_KBD_CTL_ADDR, 32'h8b);
    chk({28'h0, irq}, 32'ha);
    foreach (rx_busy_flag[i]) begin
      fork
        i_kbd_dev.send_byte(rx_busy_flag[i]);
        begin
          tick(40);
          xfer(1'b0, KMS_KBD_CTL_ADDR, KMS_WORD_RST, r);
          chk(r & 32'h10, 32'h10);
        end
      join
      tick(6);
      rdc(KMS_KBD_CTL_ADDR, 32'hab | {29'h0, ~^rx_busy_flag[i], 2'h0});
      chk({31'h0, irq[2]}, 32'h1);
      rdc(KMS_KBD_DATA_ADDR, {24'h0, rx_busy_flag[i]});
      rdc(KMS_KBD_CTL_ADDR, 32'h8b | {29'h0, ~^rx_busy_flag[i], 2'h0});
    end
    fork
      i_ptr_dev.recv_byte(got, ok);
      begin
        wr(KMS_PTR_DATA_ADDR, 8'h5a);
        tick(3);
        rdc(KMS_PTR_CTL_ADDR, 32'h4a);
        // a byte written while sending is dropped
        wr(KMS_PTR_DATA_ADDR, 8'hc3);
      end
    join
    chk({31'h0, ok}, 32'h1);
    chk({22'h0, got}, {22'h0, 1'b1, ~^8'h5a, 8'h5a});
    tick(6);
    rdc(KMS_PTR_CTL_ADDR, 32'h8b);
    i_ptr_dev.send_byte(8'h81);
    tick(6);
    chk({31'h0, irq[0]}, 32'h1);
    rdc(KMS_PTR_DATA_ADDR, 32'h81);
    end_of_test();
  end
endmodule

`default_nettype wire

// >>> core/kms_pkg.sv
package kms_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] KMS_KBD_DATA_ADDR = 32'h03200004;
  localparam logic [31:0] KMS_KBD_CTL_ADDR = 32'h03200008;
  localparam logic [31:0] KMS_PTR_DATA_ADDR = 32'h032000a8;
  localparam logic [31:0] KMS_PTR_CTL_ADDR = 32'h032000ac;

  // ----------------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------------
  localparam int KMS_CTL_FRC_CLK = 0;
  localparam int KMS_CTL_FRC_DAT = 1;
  localparam int KMS_CTL_RXP = 2;
  localparam int KMS_CTL_EN = 3;
  localparam int KMS_CTL_RXB = 4;
  localparam int KMS_CTL_RXF = 5;
  localparam int KMS_CTL_TXB = 6;
  localparam int KMS_CTL_TXE = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KMS_BYTE_RST = 8'h00;
  localparam logic [31:0] KMS_WORD_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int KMS_CLK_HZ = 25000000;
  localparam int KMS_INHIBIT_US = 100;
  // least time, rounded up to whole cycles
  localparam int KMS_INHIBIT_CYC =
    (KMS_INHIBIT_US * (KMS_CLK_HZ / 1000) + 999) / 1000;
  localparam int KMS_TMR_W = 13;

  // ----------------------------------------------------------------
  // frame bit counts
  // ----------------------------------------------------------------
  localparam logic [3:0] KMS_DATA_BITS = 4'h8;
  localparam logic [3:0] KMS_PAR_IDX = 4'h8;
  localparam logic [3:0] KMS_STOP_IDX = 4'h9;

  // ----------------------------------------------------------------
  // register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] KMS_SEL_KBD_DATA = 2'h0;
  localparam logic [1:0] KMS_SEL_KBD_CTL = 2'h1;
  localparam logic [1:0] KMS_SEL_PTR_DATA = 2'h2;
  localparam logic [1:0] KMS_SEL_PTR_CTL = 2'h3;

  typedef enum logic [1:0] {
    KMS_IDLE,
    KMS_RX,
    KMS_INH,
    KMS_TX
  } kms_state_t;

  typedef struct packed {
    kms_state_t st;
    logic [3:0] cnt;
    logic [KMS_TMR_W-1:0] tmr;
    logic [7:0] shf;
    logic [7:0] rxd;
    logic rx_full;
    logic rx_parity_bit;
    logic rpar;
    logic txp;
    logic clk_prev;
    logic drv_clk;
    logic drv_dat;
    logic en;
    logic frc_dat;
    logic frc_clk;
  } kms_chan_t;

  typedef struct packed {
    logic ph_rd;
    logic ph_wr;
    logic rd_stage;
    logic ph_hit;
    logic [1:0] ph_sel;
    logic [31:0] hrdata;
  } kms_bus_t;

endpackage

// >>> core/kms_sync.sv
`timescale 1ns/1ps
`default_nettype none

module kms_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } kms_sync_t;

  kms_sync_t r_reg;
  kms_sync_t r_next;

  generate
    if (W < 1) begin : g_chk
      $error("kms_sync width must be at least one");
    end
  endgenerate

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule

`default_nettype wire

// >>> core/kms_top.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module kms_chan
  import kms_pkg::*;
#(
  parameter int INHIBIT_CYC = KMS_INHIBIT_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register access strobes
  input wire logic wr_ctl,
  input wire logic wr_dat,
  input wire logic rd_dat,
  input wire logic [7:0] wdata,
  output logic [7:0] ctl_rd,
  output logic [7:0] dat_rd,
  // interrupt requests
  output logic irq_tx,
  output logic irq_rx,
  // open-drain link lines
  input wire logic line_clk_i,
  output logic line_clk_o,
  output logic line_clk_oe,
  input wire logic line_dat_i,
  output logic line_dat_o,
  output logic line_dat_oe
);

  kms_chan_t r_reg;
  kms_chan_t r_next;
  logic [1:0] sync_q;
  logic clk_s;
  logic dat_s;
  logic fall;
  logic tx_empty;
  logic tx_busy;
  logic rx_busy;

  generate
    if (INHIBIT_CYC < 1 || INHIBIT_CYC >= (1 << KMS_TMR_W)) begin : g_chk
      $error("kms_chan inhibit count out of timer range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  kms_sync #(
    .W(2)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({line_dat_i, line_clk_i}),
    .q(sync_q)
  );

  assign clk_s = sync_q[0];
  assign dat_s = sync_q[1];
  assign fall = r_reg.clk_prev & ~clk_s;

  // ----------------------------------------------------------------
  // status terms
  // ----------------------------------------------------------------
  assign tx_busy = (r_reg.st == KMS_INH) || (r_reg.st == KMS_TX);
  assign rx_busy = (r_reg.st == KMS_RX);
  assign tx_empty = r_reg.en & ~tx_busy;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.clk_prev = clk_s;
    if (wr_ctl) begin
      // upper nibble and bit 2 are status only
      r_next.en = wdata[KMS_CTL_EN];
      r_next.frc_dat = wdata[KMS_CTL_FRC_DAT];
      r_next.frc_clk = wdata[KMS_CTL_FRC_CLK];
    end
    if (rd_dat) begin
      r_next.rx_full = 1'b0;
    end
    if (!r_reg.en) begin
      // held cleared while disabled
      r_next.st = KMS_IDLE;
      r_next.cnt = 4'h0;
      r_next.tmr = '0;
      r_next.drv_clk = 1'b0;
      r_next.drv_dat = 1'b0;
      r_next.rx_full = 1'b0;
    end else begin
      case (r_reg.st)
        KMS_IDLE: begin
          if (wr_dat) begin
            // load byte, inhibit the peripheral clock first
            r_next.shf = wdata;
            r_next.txp = ~(^wdata);
            r_next.tmr = KMS_TMR_W'(INHIBIT_CYC);
            r_next.drv_clk = 1'b1;
            r_next.st = KMS_INH;
          end else if (fall && !dat_s) begin
            // low start bit begins a peripheral frame
            r_next.cnt = 4'h0;
            r_next.st = KMS_RX;
          end
        end
        KMS_RX: begin
          if (fall) begin
            r_next.cnt = r_reg.cnt + 4'h1;
            if (r_reg.cnt < KMS_DATA_BITS) begin
              // lsb first
              r_next.shf = {dat_s, r_reg.shf[7:1]};
            end else if (r_reg.cnt == KMS_PAR_IDX) begin
              r_next.rpar = dat_s;
            end else begin
              // stop bit: byte complete; set wins over read clear
              r_next.rxd = r_reg.shf;
              r_next.rx_parity_bit = r_reg.rpar;
              r_next.rx_full = 1'b1;
              r_next.cnt = 4'h0;
              r_next.st = KMS_IDLE;
            end
          end
        end
        KMS_INH: begin
          r_next.tmr = r_reg.tmr - KMS_TMR_W'(1);
          if (r_reg.tmr == KMS_TMR_W'(1)) begin
            // release clock and present the start bit
            r_next.drv_clk = 1'b0;
            r_next.drv_dat = 1'b1;
            r_next.cnt = 4'h0;
            r_next.st = KMS_TX;
          end
        end
        KMS_TX: begin
          if (fall) begin
            r_next.cnt = r_reg.cnt + 4'h1;
            if (r_reg.cnt < KMS_DATA_BITS) begin
              r_next.drv_dat = ~r_reg.shf[0];
              r_next.shf = {1'b0, r_reg.shf[7:1]};
            end else if (r_reg.cnt == KMS_PAR_IDX) begin
              r_next.drv_dat = ~r_reg.txp;
            end else if (r_reg.cnt == KMS_STOP_IDX) begin
              // stop bit is the released line
              r_next.drv_dat = 1'b0;
            end else begin
              // acknowledge slot: line level ignored
              r_next.cnt = 4'h0;
              r_next.st = KMS_IDLE;
            end
          end
        end
        default: begin
          r_next.st = KMS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign line_clk_o = 1'b0;
  assign line_dat_o = 1'b0;
  assign line_clk_oe = r_reg.frc_clk | r_reg.drv_clk;
  assign line_dat_oe = r_reg.frc_dat | r_reg.drv_dat;

  always_comb begin
    ctl_rd = KMS_BYTE_RST;
    ctl_rd[KMS_CTL_TXE] = tx_empty;
    ctl_rd[KMS_CTL_TXB] = tx_busy;
    ctl_rd[KMS_CTL_RXF] = r_reg.rx_full;
    ctl_rd[KMS_CTL_RXB] = rx_busy;
    ctl_rd[KMS_CTL_EN] = r_reg.en;
    ctl_rd[KMS_CTL_RXP] = r_reg.rx_parity_bit;
    ctl_rd[KMS_CTL_FRC_DAT] = dat_s;
    ctl_rd[KMS_CTL_FRC_CLK] = clk_s;
  end

  assign dat_rd = r_reg.rxd;
  assign irq_tx = tx_empty;
  assign irq_rx = r_reg.rx_full;

endmodule

module kms_top
  import kms_pkg::*;
#(
  parameter int INHIBIT_CYC = KMS_INHIBIT_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // keyboard link
  input wire logic kbd_line_clk_i,
  output logic kbd_line_clk_o,
  output logic kbd_line_clk_oe,
  input wire logic kbd_line_dat_i,
  output logic kbd_line_dat_o,
  output logic kbd_line_dat_oe,
  // pointer link
  input wire logic pointer_line_clk_i,
  output logic pointer_line_clk_o,
  output logic pointer_line_clk_oe,
  input wire logic pointer_line_dat_i,
  output logic pointer_line_dat_o,
  output logic pointer_line_dat_oe,
  // interrupt requests
  output logic irq_group_b_tx,
  output logic irq_group_b_rx,
  output logic irq_group_d_tx,
  output logic irq_group_d_rx
);

  kms_bus_t r_reg;
  kms_bus_t r_next;
  logic take;
  logic hit;
  logic [1:0] sel;
  logic [3:0] wr_ctl;
  logic [3:0] wr_dat;
  logic [3:0] rd_dat;
  logic [7:0] kbd_ctl_rd;
  logic [7:0] kbd_dat_rd;
  logic [7:0] ptr_ctl_rd;
  logic [7:0] ptr_dat_rd;
  logic [7:0] rd_byte;
  logic rd_now;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign take = hsel & hready & htrans[1];

  always_comb begin
    hit = 1'b1;
    sel = KMS_SEL_KBD_DATA;
    case (haddr)
      KMS_KBD_DATA_ADDR: sel = KMS_SEL_KBD_DATA;
      KMS_KBD_CTL_ADDR: sel = KMS_SEL_KBD_CTL;
      KMS_PTR_DATA_ADDR: sel = KMS_SEL_PTR_DATA;
      KMS_PTR_CTL_ADDR: sel = KMS_SEL_PTR_CTL;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // data-phase strobes
  // ----------------------------------------------------------------
  assign rd_now = r_reg.ph_rd & ~r_reg.rd_stage;

  always_comb begin
    wr_ctl = 4'h0;
    wr_dat = 4'h0;
    rd_dat = 4'h0;
    if (r_reg.ph_wr && r_reg.ph_hit) begin
      wr_ctl[r_reg.ph_sel] = ~r_reg.ph_sel[0] ? 1'b0 : 1'b1;
      wr_dat[r_reg.ph_sel] = ~r_reg.ph_sel[0];
    end
    if (rd_now && r_reg.ph_hit) begin
      rd_dat[r_reg.ph_sel] = ~r_reg.ph_sel[0];
    end
  end

  always_comb begin
    case (r_reg.ph_sel)
      KMS_SEL_KBD_DATA: rd_byte = kbd_dat_rd;
      KMS_SEL_KBD_CTL: rd_byte = kbd_ctl_rd;
      KMS_SEL_PTR_DATA: rd_byte = ptr_dat_rd;
      KMS_SEL_PTR_CTL: rd_byte = ptr_ctl_rd;
      default: rd_byte = KMS_BYTE_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ph_wr = 1'b0;
    if (rd_now) begin
      // one wait state so read data leave a register
      r_next.rd_stage = 1'b1;
      r_next.hrdata = r_reg.ph_hit ? {24'h000000, rd_byte} : KMS_WORD_RST;
    end
    if (r_reg.ph_rd && r_reg.rd_stage) begin
      r_next.ph_rd = 1'b0;
      r_next.rd_stage = 1'b0;
    end
    if (take) begin
      r_next.ph_rd = ~hwrite;
      r_next.ph_wr = hwrite;
      r_next.ph_hit = hit;
      r_next.ph_sel = sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = ~rd_now;
  assign hrdata = r_reg.hrdata;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  kms_chan #(
    .INHIBIT_CYC(INHIBIT_CYC)
  ) u_kbd (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_ctl(wr_ctl[KMS_SEL_KBD_CTL]),
    .wr_dat(wr_dat[KMS_SEL_KBD_DATA]),
    .rd_dat(rd_dat[KMS_SEL_KBD_DATA]),
    .wdata(hwdata[7:0]),
    .ctl_rd(kbd_ctl_rd),
    .dat_rd(kbd_dat_rd),
    .irq_tx(irq_group_b_tx),
    .irq_rx(irq_group_b_rx),
    .line_clk_i(kbd_line_clk_i),
    .line_clk_o(kbd_line_clk_o),
    .line_clk_oe(kbd_line_clk_oe),
    .line_dat_i(kbd_line_dat_i),
    .line_dat_o(kbd_line_dat_o),
    .line_dat_oe(kbd_line_dat_oe)
  );

  kms_chan #(
    .INHIBIT_CYC(INHIBIT_CYC)
  ) u_ptr (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_ctl(wr_ctl[KMS_SEL_PTR_CTL]),
    .wr_dat(wr_dat[KMS_SEL_PTR_DATA]),
    .rd_dat(rd_dat[KMS_SEL_PTR_DATA]),
    .wdata(hwdata[7:0]),
    .ctl_rd(ptr_ctl_rd),
    .dat_rd(ptr_dat_rd),
    .irq_tx(irq_group_d_tx),
    .irq_rx(irq_group_d_rx),
    .line_clk_i(pointer_line_clk_i),
    .line_clk_o(pointer_line_clk_o),
    .line_clk_oe(pointer_line_clk_oe),
    .line_dat_i(pointer_line_dat_i),
    .line_dat_o(pointer_line_dat_o),
    .line_dat_oe(pointer_line_dat_oe)
  );

endmodule

`default_nettype wire
